/* File: rtl/strap_cfg_pkg.sv */
`default_nettype none

package strap_cfg_pkg;

    // --------------------------------------------------------------------
    // Strap fields as captured at reset release
    // --------------------------------------------------------------------
    typedef struct packed {
        logic       test;
        logic [2:0] select;
        logic [1:0] if_mode;
    } strap_s;

    localparam int STRAP_W = 6;

    // --------------------------------------------------------------------
    // Strap encodings
    // --------------------------------------------------------------------
    localparam logic [1:0] IF_STRAP_I2C0 = 2'h0;
    localparam logic [1:0] IF_STRAP_I2C1 = 2'h1;
    localparam logic [1:0] IF_STRAP_ALT  = 2'h2;
    localparam logic [1:0] IF_STRAP_SPI  = 2'h3;

    localparam logic [2:0] SEL_EEPROM_PROG  = 3'h0;
    localparam logic [2:0] SEL_SKIP_AUTOCFG = 3'h3;

    // --------------------------------------------------------------------
    // Default I2C slave addresses (seven bits)
    // --------------------------------------------------------------------
    localparam logic [6:0] I2C_ADDR_0 = 7'h74;
    localparam logic [6:0] I2C_ADDR_1 = 7'h75;
    localparam logic [6:0] I2C_ADDR_2 = 7'h76;

    // --------------------------------------------------------------------
    // Modes and states
    // --------------------------------------------------------------------
    typedef enum logic [1:0] {
        HOST_I2C,
        HOST_SPI_SLAVE,
        HOST_SPI_MASTER_BOOT
    } host_if_e;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_ROM,
        SRC_EXT_EEPROM,
        SRC_INT_EEPROM
    } cfg_source_e;

    typedef enum logic [1:0] {
        ST_SAMPLE,
        ST_AUTOCFG,
        ST_RUN
    } state_e;

    localparam int GPIO_W    = 4;
    localparam int GPIO_TEST = 3;

endpackage

`default_nettype wire

/* File: rtl/reset_strap_config_select.sv */
// How it works
// - Configuration comes from test, select and interface straps sampled at reset release.
// - Sampled strap levels are captured into a readable status register at release.
// - After capture the strap pins act as GPIO, chip select and MISO.
// - Test strap high with select other than 011 enters manufacturing test; select straps choose the test mode.
// - Internal-EEPROM parts: test 1, select 000, interface 11 allows programmer access.
// - Test 1 with select 011 starts normally but skips auto-configuration.
// - Interface 00 and 01 give I2C with addresses 1110100 and 1110101; ROM source on no-EEPROM parts.
// - No-EEPROM parts: 10 is SPI slave from ROM; 11 boots as SPI master.
// - Select straps pick configuration 0 to 7 as a binary number.
// - Strapped I2C address is only a default; later writes replace it.
// - A read-only 12-bit identity and 4-bit revision are presented.
// - As boot SPI master the device drives commands, addresses and data on MOSI.
// - After boot as SPI master, chip select stops driving and becomes input.
`default_nettype none

module reset_strap_config_select
    import strap_cfg_pkg::*;
#(
    parameter logic        HAS_INT_EEPROM = 1'b0,
    // Arbitrary identity values
    parameter logic [11:0] IDENT_CODE     = 12'h5a3,
    parameter logic [3:0]  REV_CODE       = 4'h1
) (
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    input  wire logic [GPIO_W-1:0] general_io_i,
    output var  logic [GPIO_W-1:0] general_io_o,
    output var  logic [GPIO_W-1:0] general_io_oe_n_o,
    input  wire logic [GPIO_W-1:0] gpio_out_i,
    input  wire logic [GPIO_W-1:0] gpio_drive_i,
    input  wire logic              spi_select_low_i,
    output var  logic              spi_select_low_o,
    output var  logic              spi_select_low_oe_n_o,
    input  wire logic              miso_i,
    output var  logic              miso_o,
    output var  logic              miso_oe_n_o,
    output var  logic              mosi_o,
    output var  logic              mosi_oe_n_o,
    output var  logic              sclk_o,
    output var  logic              sclk_oe_n_o,
    input  wire logic              boot_select_low_i,
    input  wire logic              boot_mosi_i,
    input  wire logic              boot_sclk_i,
    input  wire logic              autocfg_done_i,
    input  wire logic              slave_miso_i,
    input  wire logic              slave_miso_en_i,
    input  wire logic              i2c_sda_low_i,
    input  wire logic              i2c_addr_wr_i,
    input  wire logic [6:0]        i2c_addr_wdata_i,
    output var  strap_s            strap_capture_status_o,
    output var  logic              straps_captured_o,
    output var  host_if_e          host_if_o,
    output var  cfg_source_e       cfg_source_o,
    output var  logic [2:0]        config_index_o,
    output var  logic              test_mode_o,
    output var  logic [2:0]        test_select_o,
    output var  logic              skip_autocfg_o,
    output var  logic              eeprom_program_o,
    output var  logic              autocfg_busy_o,
    output var  logic [6:0]        i2c_slave_address_reg_o,
    output var  logic [7:0]        ident_reg_hi_o,
    output var  logic [7:0]        ident_reg_lo_o
);

    // ------------------------------------------------------------------
    // Strap decode from live pin levels
    // ------------------------------------------------------------------
    state_e      state;
    state_e      next_state;
    strap_s      now_s;
    logic        dec_skip;
    logic        dec_test;
    logic        dec_prog;
    host_if_e    dec_host;
    logic [6:0]  dec_addr;
    cfg_source_e dec_source;
    logic        capture;

    assign now_s.test    = general_io_i[GPIO_TEST];
    assign now_s.select  = general_io_i[2:0];
    assign now_s.if_mode = {miso_i, spi_select_low_i};

    assign capture  = (state == ST_SAMPLE);
    assign dec_skip = now_s.test && (now_s.select == SEL_SKIP_AUTOCFG);
    assign dec_test = now_s.test && !dec_skip;
    assign dec_prog = HAS_INT_EEPROM && now_s.test
                      && (now_s.select == SEL_EEPROM_PROG)
                      && (now_s.if_mode == IF_STRAP_SPI);

    assign dec_host =
        (now_s.if_mode == IF_STRAP_SPI) ?
            (HAS_INT_EEPROM ? HOST_SPI_SLAVE : HOST_SPI_MASTER_BOOT) :
        (now_s.if_mode == IF_STRAP_ALT) ?
            (HAS_INT_EEPROM ? HOST_I2C : HOST_SPI_SLAVE) :
        HOST_I2C;

    assign dec_addr =
        (now_s.if_mode == IF_STRAP_I2C1) ? I2C_ADDR_1 :
        (now_s.if_mode == IF_STRAP_ALT)  ? I2C_ADDR_2 : I2C_ADDR_0;

    assign dec_source =
        (dec_test || dec_skip)            ? SRC_NONE       :
        HAS_INT_EEPROM                    ? SRC_INT_EEPROM :
        (now_s.if_mode == IF_STRAP_SPI)   ? SRC_EXT_EEPROM : SRC_ROM;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_SAMPLE: begin
                next_state = (dec_source == SRC_NONE) ? ST_RUN : ST_AUTOCFG;
            end
            ST_AUTOCFG: begin
                if (autocfg_done_i) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ST_SAMPLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Captured configuration, held until the next reset
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strap_capture_status_o <= '0;
            straps_captured_o      <= 1'b0;
            host_if_o              <= HOST_I2C;
            cfg_source_o           <= SRC_NONE;
            config_index_o         <= '0;
            test_mode_o            <= 1'b0;
            test_select_o          <= '0;
            skip_autocfg_o         <= 1'b0;
            eeprom_program_o       <= 1'b0;
        end else if (capture) begin
            strap_capture_status_o <= now_s;
            straps_captured_o      <= 1'b1;
            host_if_o              <= dec_host;
            cfg_source_o           <= dec_source;
            config_index_o         <= now_s.select;
            test_mode_o            <= dec_test;
            test_select_o          <= dec_test ? now_s.select : '0;
            skip_autocfg_o         <= dec_skip;
            eeprom_program_o       <= dec_prog;
        end
    end

    // ------------------------------------------------------------------
    // I2C address register and identity
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            i2c_slave_address_reg_o <= I2C_ADDR_0;
        end else if (capture) begin
            i2c_slave_address_reg_o <= dec_addr;
        end else if (i2c_addr_wr_i) begin
            i2c_slave_address_reg_o <= i2c_addr_wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ident_reg_hi_o <= IDENT_CODE[11:4];
            ident_reg_lo_o <= {IDENT_CODE[3:0], REV_CODE};
        end else begin
            ident_reg_hi_o <= IDENT_CODE[11:4];
            ident_reg_lo_o <= {IDENT_CODE[3:0], REV_CODE};
        end
    end

    // ------------------------------------------------------------------
    // Run-time pin roles
    // ------------------------------------------------------------------
    logic master_boot;
    logic slave_live;
    logic i2c_live;

    assign master_boot = (state == ST_AUTOCFG) && (host_if_o == HOST_SPI_MASTER_BOOT);
    assign slave_live  = (state != ST_SAMPLE) && !master_boot && (host_if_o != HOST_I2C);
    assign i2c_live    = (state != ST_SAMPLE) && (host_if_o == HOST_I2C);

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            autocfg_busy_o        <= 1'b0;
            spi_select_low_o      <= 1'b1;
            spi_select_low_oe_n_o <= 1'b1;
            miso_o                <= 1'b0;
            miso_oe_n_o           <= 1'b1;
            mosi_o                <= 1'b0;
            mosi_oe_n_o           <= 1'b1;
            sclk_o                <= 1'b0;
            sclk_oe_n_o           <= 1'b1;
        end else begin
            autocfg_busy_o        <= (next_state == ST_AUTOCFG);
            spi_select_low_o      <= boot_select_low_i;
            spi_select_low_oe_n_o <= !master_boot;
            miso_o                <= slave_miso_i;
            miso_oe_n_o           <= !(slave_live && slave_miso_en_i);
            mosi_o                <= master_boot ? boot_mosi_i : 1'b0;
            mosi_oe_n_o           <= !(master_boot || (i2c_live && i2c_sda_low_i));
            sclk_o                <= boot_sclk_i;
            sclk_oe_n_o           <= !master_boot;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < GPIO_W; gi++) begin : g_gpio
            always_ff @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    general_io_o[gi]      <= 1'b0;
                    general_io_oe_n_o[gi] <= 1'b1;
                end else begin
                    general_io_o[gi]      <= gpio_out_i[gi];
                    general_io_oe_n_o[gi] <= capture || !gpio_drive_i[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_status_held: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        straps_captured_o |=> $stable(strap_capture_status_o) && straps_captured_o)
        else $error("captured straps changed");

    a_pins_quiet: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !straps_captured_o |-> (&general_io_oe_n_o) && spi_select_low_oe_n_o && miso_oe_n_o)
        else $error("strap pin driven before capture");

    a_capture_value: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (state == ST_SAMPLE) |=> strap_capture_status_o == $past(now_s))
        else $error("status differs from sampled straps");

    a_test_mode: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        straps_captured_o && strap_capture_status_o.test
        && strap_capture_status_o.select != SEL_SKIP_AUTOCFG
        |-> test_mode_o && test_select_o == strap_capture_status_o.select
            && cfg_source_o == SRC_NONE)
        else $error("test mode decode wrong");

    a_skip_start: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        $rose(straps_captured_o) && skip_autocfg_o |-> state == ST_RUN && !test_mode_o)
        else $error("skip mode still auto-configures");

    a_prog_mode: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        straps_captured_o |-> eeprom_program_o == (HAS_INT_EEPROM
            && strap_capture_status_o.test
            && strap_capture_status_o.select == SEL_EEPROM_PROG
            && strap_capture_status_o.if_mode == IF_STRAP_SPI))
        else $error("programming mode decode wrong");

    a_i2c_default: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        $rose(straps_captured_o) && strap_capture_status_o.if_mode == IF_STRAP_I2C1
        |-> i2c_slave_address_reg_o == I2C_ADDR_1 && host_if_o == HOST_I2C)
        else $error("default I2C address wrong");

    a_addr_write: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        straps_captured_o && i2c_addr_wr_i |=> i2c_slave_address_reg_o == $past(i2c_addr_wdata_i))
        else $error("I2C address write lost");

    a_cfg_index: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        straps_captured_o |-> config_index_o == strap_capture_status_o.select)
        else $error("configuration index wrong");

    a_master_mosi: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        master_boot |=> !mosi_oe_n_o && !spi_select_low_oe_n_o && mosi_o == $past(boot_mosi_i))
        else $error("boot master not driving");

    a_select_release: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (state == ST_AUTOCFG) && autocfg_done_i |=> ##1 spi_select_low_oe_n_o && sclk_oe_n_o)
        else $error("chip select still driven after boot");

    a_ident: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        {ident_reg_hi_o, ident_reg_lo_o} == {IDENT_CODE, REV_CODE})
        else $error("identity value wrong");

endmodule

`default_nettype wire

/* File: tb/strap_board_model.sv */
`default_nettype none

module strap_board_model
    import strap_cfg_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    input  wire strap_s     strap_i,
    input  wire logic       host_cs_low_i,
    input  wire logic [3:0] gpio_o_i,
    input  wire logic [3:0] gpio_oe_n_i,
    input  wire logic       cs_o_i,
    input  wire logic       cs_oe_n_i,
    input  wire logic       miso_o_i,
    input  wire logic       miso_oe_n_i,
    output var  logic [3:0] gpio_pin_o,
    output var  logic       cs_pin_o,
    output var  logic       miso_pin_o,
    output var  logic       eeprom_cs_low_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Strap resistors hold through reset and two edges after it
    // ------------------------------------------------------------
    logic [1:0] hold_cnt;
    logic       pat;
    logic       strap_held;
    logic [3:0] gpio_strap;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_cnt <= 2'h0;
        end else if (hold_cnt != 2'h3) begin
            hold_cnt <= hold_cnt + 2'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        pat <= (pat === 1'b1) ? 1'b0 : 1'b1;
    end

    assign strap_held = !reset_n_i || (hold_cnt < 2'h2);
    assign gpio_strap = {strap_i.test, strap_i.select};
    // Board lines change after the hold so latched values are exercised
    assign gpio_pin_o = (~gpio_oe_n_i & gpio_o_i)
                      | (gpio_oe_n_i & (strap_held ? gpio_strap : ~gpio_strap));
    assign eeprom_cs_low_o = cs_oe_n_i ? 1'b1 : cs_o_i;
    assign cs_pin_o = !cs_oe_n_i ? cs_o_i
                    : strap_held ? strap_i.if_mode[0] : host_cs_low_i;
    assign miso_pin_o = !miso_oe_n_i ? miso_o_i
                      : strap_held ? strap_i.if_mode[1]
                      : !eeprom_cs_low_o ? pat : 1'b1;
endmodule

`default_nettype wire

/* File: tb/reset_strap_config_select_bench.sv */
`default_nettype none

module reset_strap_config_select_bench
    import strap_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] ID_VAL  = 12'h9c6; // Arbitrary value
    localparam logic [3:0]  REV_VAL = 4'h2;    // Arbitrary value

    logic        mclk, reset_n, host_cs_low, boot_select_low, boot_mosi, boot_sclk;
    logic        autocfg_done, slave_miso, slave_miso_en, i2c_sda_low, i2c_addr_wr;
    logic [3:0]  gpio_out, gpio_drive;
    logic [6:0]  i2c_addr_wdata;
    strap_s      strap, status;
    logic [3:0]  gpio_o, gpio_oe_n, gpio_pin;
    logic        cs_o, cs_oe_n, cs_pin, miso_o, miso_oe_n, miso_pin, eeprom_cs_low;
    logic        mosi_o, mosi_oe_n, sclk_o, sclk_oe_n, captured, test_mode, skip, prog, busy;
    host_if_e    host_if;
    cfg_source_e cfg_src;
    logic [2:0]  cfg_idx, test_sel;
    logic [6:0]  addr;
    logic [7:0]  id_hi, id_lo;
    int          n_errors, checks, cycles;

    reset_strap_config_select #(
        .HAS_INT_EEPROM(1'b0),
        .IDENT_CODE    (ID_VAL),
        .REV_CODE      (REV_VAL)
    ) i_dut (
        .mclk_i(mclk), .reset_n_i(reset_n), .general_io_i(gpio_pin),
        .general_io_o(gpio_o), .general_io_oe_n_o(gpio_oe_n), .gpio_out_i(gpio_out),
        .gpio_drive_i(gpio_drive), .spi_select_low_i(cs_pin), .spi_select_low_o(cs_o),
        .spi_select_low_oe_n_o(cs_oe_n), .miso_i(miso_pin), .miso_o(miso_o),
        .miso_oe_n_o(miso_oe_n), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n),
        .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n), .boot_select_low_i(boot_select_low),
        .boot_mosi_i(boot_mosi), .boot_sclk_i(boot_sclk), .autocfg_done_i(autocfg_done),
        .slave_miso_i(slave_miso), .slave_miso_en_i(slave_miso_en),
        .i2c_sda_low_i(i2c_sda_low), .i2c_addr_wr_i(i2c_addr_wr),
        .i2c_addr_wdata_i(i2c_addr_wdata), .strap_capture_status_o(status),
        .straps_captured_o(captured), .host_if_o(host_if), .cfg_source_o(cfg_src),
        .config_index_o(cfg_idx), .test_mode_o(test_mode), .test_select_o(test_sel),
        .skip_autocfg_o(skip), .eeprom_program_o(prog), .autocfg_busy_o(busy),
        .i2c_slave_address_reg_o(addr), .ident_reg_hi_o(id_hi), .ident_reg_lo_o(id_lo)
    );

    strap_board_model i_board (
        .mclk_i(mclk), .reset_n_i(reset_n), .strap_i(strap), .host_cs_low_i(host_cs_low),
        .gpio_o_i(gpio_o), .gpio_oe_n_i(gpio_oe_n), .cs_o_i(cs_o), .cs_oe_n_i(cs_oe_n),
        .miso_o_i(miso_o), .miso_oe_n_i(miso_oe_n), .gpio_pin_o(gpio_pin),
        .cs_pin_o(cs_pin), .miso_pin_o(miso_pin), .eeprom_cs_low_o(eeprom_cs_low)
    );

    // ------------------------------------------------------------
    // Clock, timeout and common tasks
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apply_reset(input strap_s s);
        @(negedge mclk);
        reset_n = 1'b0;
        strap = s;
        repeat (6) @(negedge mclk);
        cmp("gpio_oe_reset", 8'(gpio_oe_n), 8'h0f);
        cmp("captured_reset", 8'(captured), 8'h00);
        reset_n = 1'b1;
        repeat (2) @(negedge mclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_decode();
        strap_s     s;
        logic [1:0] exp_if;
        logic [1:0] exp_src;
        for (int i = 0; i < 64; i++) begin
            s = strap_s'(6'(i));
            apply_reset(s);
            exp_if = (s.if_mode == IF_STRAP_SPI) ? HOST_SPI_MASTER_BOOT
                   : (s.if_mode == IF_STRAP_ALT) ? HOST_SPI_SLAVE : HOST_I2C;
            exp_src = s.test ? SRC_NONE : (s.if_mode == IF_STRAP_SPI) ? SRC_EXT_EEPROM : SRC_ROM;
            cmp("status", 8'(status), 8'(s));
            cmp("captured", 8'(captured), 8'h01);
            cmp("source", 8'(cfg_src), 8'(exp_src));
            cmp("skip", 8'(skip), 8'(s.test && s.select == SEL_SKIP_AUTOCFG));
            cmp("busy", 8'(busy), 8'(!s.test));
            cmp("prog", 8'(prog), 8'h00);
            if (!s.test || (s.select == SEL_SKIP_AUTOCFG && s.if_mode != IF_STRAP_SPI)) begin
                cmp("host_if", 8'(host_if), 8'(exp_if));
                if (!s.if_mode[1]) cmp("addr", 8'(addr), 8'(s.if_mode[0] ? 7'h75 : 7'h74));
            end
            if (!s.test) cmp("index", 8'(cfg_idx), 8'(s.select));
            else cmp("test_sel", 8'(test_sel),
                     8'(s.select == SEL_SKIP_AUTOCFG ? 3'h0 : s.select));
            if (s.select != SEL_SKIP_AUTOCFG) cmp("test_mode", 8'(test_mode), 8'(s.test));
        end
    endtask

    task automatic sc_hold();
        apply_reset(strap_s'(6'h15));
        gpio_drive = 4'h5;
        gpio_out = 4'h7;
        i2c_sda_low = 1'b1;
        i2c_addr_wr = 1'b1;
        i2c_addr_wdata = 7'h2b;
        @(negedge mclk);
        i2c_addr_wr = 1'b0;
        @(negedge mclk);
        cmp("gpio_oe", 8'(gpio_oe_n), 8'h0a);
        cmp("gpio_out", 8'(gpio_o & ~gpio_oe_n), 8'h05);
        cmp("sda_oe", 8'(mosi_oe_n), 8'h00);
        cmp("sda", 8'(mosi_o), 8'h00);
        cmp("addr_wr", 8'(addr), 8'h2b);
        repeat (4) @(negedge mclk);
        cmp("status_hold", 8'(status), 8'h15);
        cmp("addr_hold", 8'(addr), 8'h2b);
        gpio_drive = 4'h0;
        i2c_sda_low = 1'b0;
    endtask

    task automatic sc_boot();
        apply_reset(strap_s'(6'h03));
        cmp("cs_oe", 8'(cs_oe_n), 8'h00);
        cmp("mosi_oe", 8'(mosi_oe_n), 8'h00);
        cmp("sclk_oe", 8'(sclk_oe_n), 8'h00);
        boot_mosi = 1'b1;
        boot_select_low = 1'b0;
        boot_sclk = 1'b1;
        @(negedge mclk);
        cmp("mosi", 8'(mosi_o), 8'h01);
        cmp("sclk", 8'(sclk_o), 8'h01);
        cmp("eeprom_cs", 8'(eeprom_cs_low), 8'h00);
        boot_mosi = 1'b0;
        autocfg_done = 1'b1;
        @(negedge mclk);
        autocfg_done = 1'b0;
        cmp("mosi_low", 8'(mosi_o), 8'h00);
        cmp("cs_oe_hold", 8'(cs_oe_n), 8'h00);
        @(negedge mclk);
        cmp("cs_oe_off", 8'(cs_oe_n), 8'h01);
        cmp("busy_off", 8'(busy), 8'h00);
        host_cs_low = 1'b0;
        slave_miso = 1'b1;
        slave_miso_en = 1'b1;
        @(negedge mclk);
        cmp("miso_oe", 8'(miso_oe_n), 8'h00);
        cmp("miso", 8'(miso_o), 8'h01);
        host_cs_low = 1'b1;
        slave_miso_en = 1'b0;
    endtask

    task automatic sc_ident();
        cmp("id_hi", id_hi, ID_VAL[11:4]);
        cmp("id_lo", id_lo, {ID_VAL[3:0], REV_VAL});
    endtask

    initial begin
        {reset_n, host_cs_low, boot_select_low, boot_mosi, boot_sclk} = 5'h0c;
        {autocfg_done, slave_miso, slave_miso_en, i2c_sda_low, i2c_addr_wr} = 5'h00;
        gpio_out = 4'h0;
        gpio_drive = 4'h0;
        i2c_addr_wdata = 7'h00;
        strap = strap_s'(6'h00);
        sc_decode();
        sc_hold();
        sc_boot();
        sc_ident();
        end_sim();
    end
endmodule

`default_nettype wire
